//--- rtl/dsdr_pkg.sv
// dsdr_pkg: constants for the dual space data ram with dma port
// assumes: 16-bit byte addresses, word access only, one core clock
package dsdr_pkg;
   // -----------------------------------------------------------------
   // address map
   // -----------------------------------------------------------------
   localparam int          DSDR_ADDR_W     = 16;            // byte address width
   localparam int          DSDR_DATA_W     = 16;            // word width
   localparam int          DSDR_WORDS_TOT  = 32768;         // 64 kbyte space in words
   localparam int          DSDR_MEM_WORDS  = 4096;          // implemented words (8 kbyte)
   localparam int          DSDR_MEM_AW     = 12;            // word index width of backing ram
   localparam int          DSDR_DMA_WORDS  = 1024;          // 2 kbyte dual ported region
   localparam int          DSDR_DMA_AW     = 10;            // word index width of region
   localparam logic [15:0] DSDR_Y_BASE     = 16'h1000;      // fixed x/y boundary (build time)
   localparam logic [15:0] DSDR_Y_END      = 16'h2000;      // first byte past y space
   localparam logic [15:0] DSDR_DMA_BASE   = 16'h1800;      // region sits at top of y space
   localparam logic [15:0] DSDR_MOD_RST    = 16'h0000;      // reset value of next pointers
   // -----------------------------------------------------------------
   // address generation modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      DSDR_AM_LINEAR = 2'b00,
      DSDR_AM_MODULO = 2'b01,
      DSDR_AM_BITREV = 2'b10
   } dsdr_amode_t;
endpackage : dsdr_pkg

//--- rtl/dsdr_dma_ram.sv
// dsdr_dma_ram: two port word memory for the dma region
// assumes: both ports on one clock, registered read data
`timescale 1ns/100ps
`default_nettype none
module dsdr_dma_ram
   import dsdr_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   a_we_i,
   input  wire logic [DSDR_DMA_AW-1:0] a_addr_i,
   input  wire logic [DSDR_DATA_W-1:0] a_wdata_i,
   output logic      [DSDR_DATA_W-1:0] a_rdata_o,
   input  wire logic                   b_we_i,
   input  wire logic [DSDR_DMA_AW-1:0] b_addr_i,
   input  wire logic [DSDR_DATA_W-1:0] b_wdata_i,
   output logic      [DSDR_DATA_W-1:0] b_rdata_o
);
   logic [DSDR_DATA_W-1:0] mem_q [DSDR_DMA_WORDS];

   // -----------------------------------------------------------------
   // writes: port a (cpu) lands last and so wins a same-word clash
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (b_we_i && !(a_we_i && a_addr_i == b_addr_i)) begin
         mem_q[b_addr_i] <= b_wdata_i;
      end
      if (a_we_i) begin
         mem_q[a_addr_i] <= a_wdata_i;
      end
   end

   // registered reads on both ports
   always_ff @(posedge clk_i) begin
      a_rdata_o <= mem_q[a_addr_i];
      b_rdata_o <= mem_q[b_addr_i];
   end
endmodule : dsdr_dma_ram
`default_nettype wire

//--- rtl/dsdr_data_ram.sv
// dsdr_data_ram: x/y data memory with two address generators and a dma port
// assumes: cpu and dma on the core clock; word aligned byte addresses
//
// Functional notes
// - x and y spaces; dual reads and all other accesses alike see one combined range
// - two independent address generators give two reads per cycle
// - x space has separate read and write buses; x read serves combined reads
// - y generator supplies a parallel second read for dual operand dsp class
// - modulo addressing available on both x and y generators
// - bit reversed addressing only for writes into x space
// - every cpu write is decoded against the combined x plus y range
// - x/y boundary is a build time constant, not software changeable
// - addresses are 16-bit byte addresses, 64 kbyte range, partly implemented
// - 2 kbyte dual ported region sits at top of y space
// - cpu and dma access the region at once; dma never stalls cpu
// - same-word write clash: cpu write wins
`timescale 1ns/100ps
`default_nettype none
module dsdr_data_ram
   import dsdr_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   // x generator: read or write
   input  wire logic                   x_req_i,
   input  wire logic                   x_we_i,
   input  wire dsdr_amode_t            x_mode_i,
   input  wire logic [DSDR_ADDR_W-1:0] x_addr_i,
   input  wire logic [DSDR_ADDR_W-1:0] x_mod_start_i,
   input  wire logic [DSDR_ADDR_W-1:0] x_mod_end_i,
   input  wire logic [DSDR_ADDR_W-1:0] x_wdata_i,
   output logic      [DSDR_DATA_W-1:0] x_rdata_o,
   output logic                        x_rvalid_o,
   output logic      [DSDR_ADDR_W-1:0] x_ea_o,
   // y generator: read only, dual operand dsp class
   input  wire logic                   y_req_i,
   input  wire dsdr_amode_t            y_mode_i,
   input  wire logic [DSDR_ADDR_W-1:0] y_addr_i,
   input  wire logic [DSDR_ADDR_W-1:0] y_mod_start_i,
   input  wire logic [DSDR_ADDR_W-1:0] y_mod_end_i,
   output logic      [DSDR_DATA_W-1:0] y_rdata_o,
   output logic                        y_rvalid_o,
   output logic      [DSDR_ADDR_W-1:0] y_ea_o,
   // dma port into the dual ported region
   input  wire logic                   dma_req_i,
   input  wire logic                   dma_we_i,
   input  wire logic [DSDR_DMA_AW-1:0] dma_addr_i,
   input  wire logic [DSDR_DATA_W-1:0] dma_wdata_i,
   output logic      [DSDR_DATA_W-1:0] dma_rdata_o,
   output logic                        dma_rvalid_o
);
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // modulo step: wrap a post incremented address inside start..end
   function automatic logic [15:0] dsdr_mod(input logic [15:0] a, input logic [15:0] s,
                                            input logic [15:0] e);
      logic [15:0] nxt;
      nxt = a + 16'h0002;
      if (a == e) begin
         nxt = s;
      end
      return nxt;
   endfunction : dsdr_mod

   // bit reversal of the word index (address bits 15:1)
   function automatic logic [15:0] dsdr_rev(input logic [15:0] a);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 1; i < 16; i++) begin
         r[i] = a[16 - i];
      end
      return r;
   endfunction : dsdr_rev

   function automatic logic dsdr_in_dma(input logic [15:0] a);
      return (a >= DSDR_DMA_BASE) && (a < DSDR_Y_END);
   endfunction : dsdr_in_dma

   // -----------------------------------------------------------------
   // effective addresses
   // -----------------------------------------------------------------
   logic [15:0] x_ea;
   logic [15:0] y_ea;
   logic [15:0] x_ptr_q;
   logic [15:0] y_ptr_q;
   logic        x_bitrev;

   // bit reversal only on x writes below the boundary
   assign x_bitrev = x_mode_i == DSDR_AM_BITREV && x_we_i && x_addr_i < DSDR_Y_BASE;

   // x effective address: 16-bit byte address, word aligned
   always_comb begin
      x_ea = {x_addr_i[15:1], 1'b0};
      if (x_bitrev) begin
         x_ea = dsdr_rev(x_addr_i);
      end
   end

   // y effective address never uses bit reversal
   assign y_ea = {y_addr_i[15:1], 1'b0};

   // next pointer per generator, modulo wrap where selected
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         x_ptr_q <= DSDR_MOD_RST;
      end else if (x_req_i) begin
         x_ptr_q <= (x_mode_i == DSDR_AM_MODULO) ?
                    dsdr_mod(x_ea, x_mod_start_i, x_mod_end_i) : x_ea + 16'h0002;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         y_ptr_q <= DSDR_MOD_RST;
      end else if (y_req_i) begin
         y_ptr_q <= (y_mode_i == DSDR_AM_MODULO) ?
                    dsdr_mod(y_ea, y_mod_start_i, y_mod_end_i) : y_ea + 16'h0002;
      end
   end

   assign x_ea_o = x_ptr_q;
   assign y_ea_o = y_ptr_q;

   // -----------------------------------------------------------------
   // decode against combined space
   // -----------------------------------------------------------------
   logic x_hit_mem;
   logic y_hit_mem;
   logic x_hit_dma;
   logic y_hit_dma;
   logic [15:0] x_widx;
   logic [15:0] y_widx;

   assign x_widx    = {1'b0, x_ea[15:1]};
   assign y_widx    = {1'b0, y_ea[15:1]};
   assign x_hit_dma = dsdr_in_dma(x_ea);
   assign y_hit_dma = dsdr_in_dma(y_ea);
   assign x_hit_mem = x_widx < 16'(DSDR_MEM_WORDS) && !x_hit_dma;
   assign y_hit_mem = y_widx < 16'(DSDR_MEM_WORDS) && !y_hit_dma;

   // -----------------------------------------------------------------
   // main ram: x read/write port, independent y read port
   // -----------------------------------------------------------------
   logic [DSDR_DATA_W-1:0] main_q [DSDR_MEM_WORDS];
   logic [DSDR_DATA_W-1:0] x_main_q;
   logic [DSDR_DATA_W-1:0] y_main_q;

   always_ff @(posedge clk_i) begin
      if (x_req_i && x_we_i && x_hit_mem) begin
         main_q[x_widx[DSDR_MEM_AW-1:0]] <= x_wdata_i;
      end
   end

   // two concurrent read paths
   always_ff @(posedge clk_i) begin
      x_main_q <= main_q[x_widx[DSDR_MEM_AW-1:0]];
      y_main_q <= main_q[y_widx[DSDR_MEM_AW-1:0]];
   end

   // -----------------------------------------------------------------
   // dual ported region; the y read shares the cpu port only when idle
   // -----------------------------------------------------------------
   logic                   cpu_we;
   logic [DSDR_DMA_AW-1:0] cpu_idx;
   logic [DSDR_DMA_AW-1:0] dma_idx;
   logic [DSDR_DATA_W-1:0] cpu_dma_rd;
   logic [DSDR_DATA_W-1:0] dma_rd;
   logic [DSDR_DATA_W-1:0] y_dma_q;
   logic                   y_on_cpu;

   assign y_on_cpu = y_req_i && y_hit_dma && !(x_req_i && x_hit_dma);
   assign cpu_we   = x_req_i && x_we_i && x_hit_dma;
   assign cpu_idx  = y_on_cpu ? y_widx[DSDR_DMA_AW-1:0] : x_widx[DSDR_DMA_AW-1:0];
   assign dma_idx  = dma_addr_i;

   dsdr_dma_ram u_dma_ram (
      .clk_i     (clk_i),
      .a_we_i    (cpu_we),
      .a_addr_i  (cpu_idx),
      .a_wdata_i (x_wdata_i),
      .a_rdata_o (cpu_dma_rd),
      .b_we_i    (dma_req_i && dma_we_i),
      .b_addr_i  (dma_idx),
      .b_wdata_i (dma_wdata_i),
      .b_rdata_o (dma_rd)
   );

   // shadow copy of the region: takes every write, serves y while x holds the cpu port
   // limitation: a y read beside an x write into the region sees the word at the write index
   logic [DSDR_DMA_AW-1:0] shd_idx;
   logic [DSDR_DATA_W-1:0] shd_rd;

   assign shd_idx = cpu_we ? x_widx[DSDR_DMA_AW-1:0] : y_widx[DSDR_DMA_AW-1:0];

   dsdr_dma_ram u_dma_shadow (
      .clk_i     (clk_i),
      .a_we_i    (cpu_we),
      .a_addr_i  (shd_idx),
      .a_wdata_i (x_wdata_i),
      .a_rdata_o (shd_rd),
      .b_we_i    (dma_req_i && dma_we_i),
      .b_addr_i  (dma_idx),
      .b_wdata_i (dma_wdata_i),
      .b_rdata_o ()
   );

   // y read that collides with an x access in the region uses the shadow copy
   logic y_dma_alt_q;
   logic x_dma_q;
   logic y_dma_q_sel;
   logic x_mem_q;
   logic y_mem_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         x_dma_q     <= 1'b0;
         y_dma_q_sel <= 1'b0;
         y_dma_alt_q <= 1'b0;
         x_mem_q     <= 1'b0;
         y_mem_q     <= 1'b0;
      end else begin
         x_dma_q     <= x_hit_dma;
         y_dma_q_sel <= y_hit_dma;
         y_dma_alt_q <= y_hit_dma && !y_on_cpu;
         x_mem_q     <= x_hit_mem;
         y_mem_q     <= y_hit_mem;
      end
   end

   assign y_dma_q = y_dma_alt_q ? shd_rd : cpu_dma_rd;

   // -----------------------------------------------------------------
   // registered outputs
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         x_rvalid_o   <= 1'b0;
         y_rvalid_o   <= 1'b0;
         dma_rvalid_o <= 1'b0;
      end else begin
         x_rvalid_o   <= x_req_i && !x_we_i;
         y_rvalid_o   <= y_req_i;
         dma_rvalid_o <= dma_req_i && !dma_we_i;
      end
   end

   // read data select, unmapped reads as zero
   assign x_rdata_o   = x_dma_q ? cpu_dma_rd : (x_mem_q ? x_main_q : 16'h0000);
   assign y_rdata_o   = y_dma_q_sel ? y_dma_q : (y_mem_q ? y_main_q : 16'h0000);
   assign dma_rdata_o = dma_rd;
endmodule : dsdr_data_ram
`default_nettype wire

//--- tb/dsdr_data_ram_checker.sv
// dsdr_data_ram_checker: port assertions for the data ram
// assumes: bound to dsdr_data_ram; region tracking uses linear x writes
`timescale 1ns/100ps
`default_nettype none
module dsdr_data_ram_checker
   import dsdr_pkg::*;
(
   input wire logic                   clk_i,
   input wire logic                   rst_n_i,
   input wire logic                   x_req_i,
   input wire logic                   x_we_i,
   input wire dsdr_amode_t            x_mode_i,
   input wire logic [DSDR_ADDR_W-1:0] x_addr_i,
   input wire logic [DSDR_ADDR_W-1:0] x_wdata_i,
   input wire logic [DSDR_DATA_W-1:0] x_rdata_o,
   input wire logic                   x_rvalid_o,
   input wire logic                   y_req_i,
   input wire logic                   y_rvalid_o,
   input wire logic                   dma_req_i,
   input wire logic                   dma_we_i,
   input wire logic [DSDR_DMA_AW-1:0] dma_addr_i,
   input wire logic [DSDR_DATA_W-1:0] dma_wdata_i,
   input wire logic [DSDR_DATA_W-1:0] dma_rdata_o,
   input wire logic                   dma_rvalid_o
);
   logic       cw, dw, xr, dr, v_q, cl_q;
   logic [9:0] i_q;
   logic [15:0] d_q;
   // region write and read decodes
   assign cw = x_req_i && x_we_i && x_mode_i == DSDR_AM_LINEAR && x_addr_i[15:11] == 5'h03;
   assign dw = dma_req_i && dma_we_i;
   assign xr = v_q && x_req_i && !x_we_i && x_mode_i == DSDR_AM_LINEAR && x_addr_i == {5'h03, i_q, 1'b0};
   assign dr = v_q && dma_req_i && !dma_we_i && dma_addr_i == i_q && !cw;
   // last region write, cpu side first
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         v_q <= 1'b0;
         cl_q <= 1'b0;
         i_q <= '0;
         d_q <= '0;
      end else if (cw || dw) begin
         v_q <= 1'b1;
         cl_q <= cw && dw && dma_addr_i == x_addr_i[10:1];
         i_q <= cw ? x_addr_i[10:1] : dma_addr_i;
         d_q <= cw ? x_wdata_i : dma_wdata_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_x_rd_lat: assert property (x_req_i && !x_we_i |=> x_rvalid_o) else $error("x read late");
   chk_x_no_spur: assert property (!(x_req_i && !x_we_i) |=> !x_rvalid_o) else $error("x valid spurious");
   chk_y_rd_lat: assert property (y_req_i |=> y_rvalid_o) else $error("y read late");
   chk_y_no_spur: assert property (!y_req_i |=> !y_rvalid_o) else $error("y valid spurious");
   chk_dual_read: assert property (x_req_i && !x_we_i && y_req_i |=> x_rvalid_o && y_rvalid_o) else $error("dual");
   chk_dma_nostall: assert property (dma_req_i && !dma_we_i && x_req_i
      |=> dma_rvalid_o && x_rvalid_o == !$past(x_we_i)) else $error("dma stalls cpu");
   chk_rgn_rdback: assert property (dr |=> dma_rdata_o == d_q) else $error("region readback");
   chk_cpu_wins: assert property (cl_q && dr |=> dma_rdata_o == d_q) else $error("clash lost");
   chk_x_rdback: assert property (xr && !dw |=> x_rdata_o == d_q) else $error("x region readback");
   cover property (cl_q && dr);
   cover property (x_req_i && x_we_i && x_mode_i == DSDR_AM_BITREV);
   cover property (cw && dw);
   cover property (x_req_i && !x_we_i && y_req_i && dma_req_i);
endmodule : dsdr_data_ram_checker
bind dsdr_data_ram dsdr_data_ram_checker u_chk (
   .clk_i, .rst_n_i, .x_req_i, .x_we_i, .x_mode_i, .x_addr_i, .x_wdata_i, .x_rdata_o, .x_rvalid_o,
   .y_req_i, .y_rvalid_o, .dma_req_i, .dma_we_i, .dma_addr_i, .dma_wdata_i, .dma_rdata_o, .dma_rvalid_o
);
`default_nettype wire

//--- tb/dsdr_dma_model.sv
// dsdr_dma_model: dma controller side of the region port
// assumes: bench raises go_i at the falling edge for one cycle
`timescale 1ns/100ps
`default_nettype none
module dsdr_dma_model
   import dsdr_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   go_i,
   input  wire logic                   we_i,
   input  wire logic [DSDR_DMA_AW-1:0] idx_i,
   input  wire logic [DSDR_DATA_W-1:0] dat_i,
   output logic                        dma_req_o,
   output logic                        dma_we_o,
   output logic      [DSDR_DMA_AW-1:0] dma_addr_o,
   output logic      [DSDR_DATA_W-1:0] dma_wdata_o
);
   logic [DSDR_DMA_AW-1:0] a_q = '0;
   logic [DSDR_DATA_W-1:0] d_q = '0;
   // idle bus flips each cycle so nothing stale looks valid
   always_ff @(posedge clk_i) begin
      a_q <= ~dma_addr_o;
      d_q <= ~dma_wdata_o;
   end
   // request lines follow go, free of cpu timing
   always_comb begin
      dma_req_o   = go_i;
      dma_we_o    = go_i ? we_i : a_q[0];
      dma_addr_o  = go_i ? idx_i : a_q;
      dma_wdata_o = go_i ? dat_i : d_q;
   end
endmodule : dsdr_dma_model
`default_nettype wire

//--- tb/tb.sv
// tb: random and corner traffic on cpu and dma ports
// assumes: dsdr_data_ram with bound checker and dma model
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dsdr_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0;
   logic        xr = 0, xw = 0, yr = 0, go = 0, gw = 0, dq, dw;
   dsdr_amode_t xm = DSDR_AM_LINEAR, ym = DSDR_AM_LINEAR;
   logic [15:0] xa = '0, xd = '0, ya = '0, ms = '0, me = '0, dd = '0, dw_d, x_rd, y_rd, d_rd, x_ea, y_ea;
   logic [9:0]  di = '0, da;
   int          n_errors = 0, checked = 0;
   always #25 clk_i = ~clk_i;
   dsdr_data_ram dut (
      .clk_i, .rst_n_i, .x_req_i(xr), .x_we_i(xw), .x_mode_i(xm), .x_addr_i(xa), .x_mod_start_i(ms),
      .x_mod_end_i(me), .x_wdata_i(xd), .x_rdata_o(x_rd), .x_rvalid_o(), .x_ea_o(x_ea), .y_req_i(yr),
      .y_mode_i(ym), .y_addr_i(ya), .y_mod_start_i(ms), .y_mod_end_i(me), .y_rdata_o(y_rd),
      .y_rvalid_o(), .y_ea_o(y_ea), .dma_req_i(dq), .dma_we_i(dw), .dma_addr_i(da), .dma_wdata_i(dw_d),
      .dma_rdata_o(d_rd), .dma_rvalid_o());
   dsdr_dma_model u_dma (.clk_i, .go_i(go), .we_i(gw), .idx_i(di), .dat_i(dd), .dma_req_o(dq),
      .dma_we_o(dw), .dma_addr_o(da), .dma_wdata_o(dw_d));
   task automatic chk(input string nm, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   // one request cycle, then an idle cycle with flipped buses
   task automatic op(input logic a, b, c, g, h, input logic [15:0] p, q, r, input logic [9:0] i,
                     input logic [15:0] w);
      @(negedge clk_i);
      {xr, xw, yr, go, gw} = {a, b, c, g, h};
      {xa, xd, ya, di, dd} = {p, q, r, i, w};
      @(negedge clk_i);
      {xr, yr, go} = 3'h0;
      {xa, xd, ya} = ~{xa, xd, ya};
      {ms, me} = $urandom;
   endtask : op
   function automatic logic [15:0] rgn(input logic [9:0] i);
      return DSDR_DMA_BASE + {5'h00, i, 1'b0};
   endfunction : rgn
   // word index (byte address bits 15:1) mirrored end for end
   function automatic logic [15:0] brev(input logic [15:0] a);
      logic [15:0] r;
      r = 16'h0000;
      for (int b = 0; b < 15; b++) begin
         r[15 - b] = a[b + 1];
      end
      return r;
   endfunction : brev
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   // hang guard
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
   initial begin
      logic [9:0]  i;
      logic [15:0] a, c;
      void'($urandom(3));
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      // cpu write, then x, y and dma read of one word in parallel
      for (int k = 0; k < 10; k++) begin
         i = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($urandom);
         c = $urandom;
         op(1, 1, 0, 0, 0, rgn(i), c, 0, 0, 0);
         op(1, 0, 1, 1, 0, rgn(i), 0, rgn(i), i, 0);
         chk("x_rdata", x_rd, c);
         chk("y_rdata", y_rd, c);
         chk("dma_rdata", d_rd, c);
      end
      $display("test shared_region done");
      // both sides write one word in the same cycle
      for (int k = 0; k < 8; k++) begin
         i = $urandom;
         c = $urandom;
         op(1, 1, 0, 1, 1, rgn(i), c, 0, i, ~c);
         op(0, 0, 0, 1, 0, 0, 0, 0, i, 0);
         chk("clash_dma", d_rd, c);
         op(1, 0, 0, 0, 0, rgn(i), 0, 0, 0, 0);
         chk("clash_cpu", x_rd, c);
      end
      $display("test write_clash done");
      // neighbouring words written at once, both kept
      for (int k = 0; k < 8; k++) begin
         i = $urandom;
         c = $urandom;
         op(1, 1, 0, 1, 1, rgn(i), c, 0, i ^ 10'h001, ~c);
         op(1, 0, 1, 0, 0, rgn(i), 0, rgn(i ^ 10'h001), 0, 0);
         chk("both_x", x_rd, c);
         chk("both_y", y_rd, ~c);
      end
      $display("test parallel_writes done");
      // x space and lower y space through the combined write path
      for (int k = 0; k < 8; k++) begin
         c = $urandom;
         a = (k == 0) ? 16'h0FFE : {4'h0, 11'($urandom), 1'b0};
         op(1, 1, 0, 0, 0, a, c, 0, 0, 0);
         op(1, 0, 0, 0, 0, a, 0, 0, 0, 0);
         chk("x_space", x_rd, c);
         a = (k == 0) ? DSDR_Y_BASE : DSDR_Y_BASE + {5'h00, 10'($urandom), 1'b0};
         op(1, 1, 0, 0, 0, a, ~c, 0, 0, 0);
         op(0, 0, 1, 0, 0, 0, 0, a, 0, 0);
         chk("y_space", y_rd, ~c);
      end
      $display("test combined_space done");
      // address generators: modulo wrap on both, bit reversal only on x writes
      for (int k = 0; k < 8; k++) begin
         @(negedge clk_i);
         xm = DSDR_AM_MODULO;
         ym = DSDR_AM_MODULO;
         a = 16'($urandom) & 16'hFFFE;
         c = a + 16'h0010;
         {ms, me} = {a, c};
         op(1, 0, 1, 0, 0, c, 0, c, 0, 0);
         chk("x_wrap", x_ea, a);
         chk("y_wrap", y_ea, a);
         xm = DSDR_AM_BITREV;
         ym = DSDR_AM_BITREV;
         a = {4'h0, 7'($urandom), 5'h00};
         c = $urandom;
         op(1, 1, 0, 0, 0, a, c, 0, 0, 0);
         chk("x_rev_ea", x_ea, brev(a) + 16'h0002);
         op(1, 0, 1, 0, 0, a, 0, a, 0, 0);
         chk("x_rd_norev", x_ea, a + 16'h0002);
         chk("y_norev", y_ea, a + 16'h0002);
         xm = DSDR_AM_LINEAR;
         ym = DSDR_AM_LINEAR;
         op(1, 0, 0, 0, 0, brev(a), 0, 0, 0, 0);
         chk("x_rev_data", x_rd, c);
      end
      $display("test address_gen done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
